/* File: core/acs_pkg.sv */
// package for the conversion sequencer: register map, field positions, timing.
// assumes an axi4-lite master on the system clock and an external analog core.
package acs_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_INPUT_SEL = 8'h00;  // input_select_register
    localparam logic [7:0] OFS_CTRL_A = 8'h04;     // converter_control_a
    localparam logic [7:0] OFS_CTRL_B = 8'h08;     // converter_control_b
    localparam logic [7:0] OFS_RES_LOW = 8'h0c;    // result_low_byte
    localparam logic [7:0] OFS_RES_HIGH = 8'h10;   // result_high_byte
    // input_select_register fields
    localparam int CH_LSB = 0;        // channel_select_field [1:0]
    localparam int ALIGN_BIT = 5;     // result_left_align_bit
    localparam int REF_LSB = 6;       // reference_select_field [7:6]
    // converter_control_a fields
    localparam int PS_LSB = 0;        // prescaler_select_field [2:0]
    localparam int FLAG_BIT = 4;      // conversion_complete_flag, write one clears
    localparam int ATE_BIT = 5;       // auto_trigger_enable_bit
    localparam int START_BIT = 6;     // start_conversion_bit
    localparam int EN_BIT = 7;        // converter_enable_bit
    // converter_control_b fields
    localparam int TS_LSB = 0;        // trigger_source_field [2:0]
    // cycle counts, in half converter clocks to carry the .5 figures
    localparam logic [5:0] HALF_NORMAL = 6'h1a;    // 13 cycles
    localparam logic [5:0] HALF_FIRST = 6'h32;     // 25 cycles
    localparam logic [5:0] HALF_AUTO = 6'h1b;      // 13.5 cycles
    localparam logic [5:0] SH_NORMAL = 6'h03;      // 1.5 cycles
    localparam logic [5:0] SH_FIRST = 6'h1d;       // 14.5 cycles
    localparam logic [5:0] SH_AUTO = 6'h04;        // 2 cycles
    localparam logic [1:0] SYNC_CYC = 2'h3;        // system clocks of trigger sync
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] refsel;
        logic [1:0] chan;
    } acs_sel_t;
endpackage

/* File: core/acs_sequencer.sv */
// conversion sequencer: axi4-lite registers, prescaler, start/trigger control,
// result lock and alignment. the analog core gives a 10-bit result on done.
`timescale 1ns/100ps
module acs_sequencer #(
    parameter int TRIG_W = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [TRIG_W-1:0] trig_src,
    input wire logic [9:0] core_result,
    output acs_pkg::acs_sel_t conv_sel,
    output logic conv_enable,
    output logic conv_clk,
    output logic conv_sample,
    output logic conv_busy
);
    // ------------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ACS_IDLE = 3'b001,
        ACS_SYNC = 3'b010,
        ACS_CONV = 3'b100
    } acs_state_t;

    acs_state_t state_ff;
    logic [7:0] insel_ff;
    logic en_ff, ate_ff, flag_ff, start_ff, first_ff, lock_ff, auto_ff;
    logic [2:0] ps_ff, ts_ff;
    logic [9:0] res_ff;
    logic [6:0] pre_ff;
    logic [5:0] half_ff;
    logic [1:0] sync_ff;
    logic soft_req_ff, trig_prev_ff, run_ff;
    logic [7:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic aw_got_ff, w_got_ff;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // prescaler terminal count for a select value (divide by 2..128)
    function automatic logic [6:0] ps_last(input logic [2:0] sel);
        logic [6:0] d;
        d = 7'h01;
        case (sel)
            3'h0, 3'h1: d = 7'h01;
            3'h2: d = 7'h03;
            3'h3: d = 7'h07;
            3'h4: d = 7'h0f;
            3'h5: d = 7'h1f;
            3'h6: d = 7'h3f;
            default: d = 7'h7f;
        endcase
        return d;
    endfunction

    logic wr_go, rd_go, conv_tick, trig_lvl, trig_rise, done;
    logic [5:0] conv_len;
    logic [7:0] rd_byte, low_b, high_b;

    // ------------------------------------------------------------------
    // prescaler: half-period ticks of the converter clock
    // ------------------------------------------------------------------
    // terminal count gives the rising edge, half count the falling edge
    assign conv_tick = en_ff && (pre_ff == ps_last(ps_ff));  // rising converter edge
    wire mid_tick = en_ff && (pre_ff == (ps_last(ps_ff) >> 1));

    // held in reset while disabled; trigger restarts it too
    always_ff @(posedge clk) begin
        if (srst || !en_ff) begin
            pre_ff <= 7'h00;
        end else if (state_ff == ACS_SYNC && sync_ff == 2'h0) begin
            pre_ff <= 7'h00;
        end else if (pre_ff == ps_last(ps_ff)) begin
            pre_ff <= 7'h00;
        end else begin
            pre_ff <= pre_ff + 7'h01;
        end
    end

    // converter clock high in the first half of each period
    always_ff @(posedge clk) begin
        if (srst || !en_ff) begin
            conv_clk <= 1'b0;
        end else if (conv_tick) begin
            conv_clk <= 1'b1;
        end else if (mid_tick) begin
            conv_clk <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // trigger selection and edge detect
    // ------------------------------------------------------------------
    assign trig_lvl = ts_ff == 3'h0 ? flag_ff : trig_src[ts_ff];
    assign trig_rise = trig_lvl && !trig_prev_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            trig_prev_ff <= 1'b0;
        end else begin
            trig_prev_ff <= trig_lvl;
        end
    end

    // ------------------------------------------------------------------
    // conversion sequencing
    // ------------------------------------------------------------------
    // auto-triggered runs carry the extra half cycle of the trigger path
    assign conv_len = first_ff ? acs_pkg::HALF_FIRST
        : (auto_ff ? acs_pkg::HALF_AUTO : acs_pkg::HALF_NORMAL);
    assign done = (state_ff == ACS_CONV) && (mid_tick || conv_tick) && (half_ff == conv_len - 6'h01);
    logic sw_start;
    assign sw_start = wr_go && aw_addr_ff == acs_pkg::OFS_CTRL_A && w_strb_ff[0]
                      && w_data_ff[acs_pkg::START_BIT] && w_data_ff[acs_pkg::EN_BIT];

    always_ff @(posedge clk) begin
        if (srst || !en_ff) begin
            state_ff <= ACS_IDLE;
            half_ff <= 6'h00;
            sync_ff <= 2'h0;
            auto_ff <= 1'b0;
            soft_req_ff <= !srst && sw_start;  // start written with enable survives
        end else begin
            if (sw_start) begin
                soft_req_ff <= 1'b1;
            end
            case (state_ff)
                ACS_IDLE: begin
                    if (ate_ff && ts_ff != 3'h0 && trig_rise) begin
                        state_ff <= ACS_SYNC;
                        sync_ff <= acs_pkg::SYNC_CYC - 2'h1;
                        auto_ff <= 1'b1;
                    end else if ((soft_req_ff || sw_start) && conv_tick) begin
                        state_ff <= ACS_CONV;
                        half_ff <= 6'h00;
                        auto_ff <= 1'b0;
                        soft_req_ff <= 1'b0;
                    end
                end
                ACS_SYNC: begin
                    if (sync_ff == 2'h0) begin
                        state_ff <= ACS_CONV;
                        half_ff <= 6'h00;
                    end else begin
                        sync_ff <= sync_ff - 2'h1;
                    end
                end
                ACS_CONV: begin  // edges during conversion ignored
                    if (done) begin
                        half_ff <= 6'h00;
                        // flag as trigger or free running restarts at once
                        if (ate_ff && ts_ff == 3'h0) begin
                            auto_ff <= 1'b0;
                        end else begin
                            state_ff <= ACS_IDLE;
                        end
                    end else if (mid_tick || conv_tick) begin
                        half_ff <= half_ff + 6'h01;
                    end
                end
                default: state_ff <= ACS_IDLE;
            endcase
        end
    end

    // first conversion after enable is the long one
    always_ff @(posedge clk) begin
        if (srst || !en_ff) begin
            first_ff <= 1'b1;
        end else if (done) begin
            first_ff <= 1'b0;
        end
    end

    // sample-and-hold strobe at 1.5, 14.5 or 2 cycles
    always_ff @(posedge clk) begin
        if (srst) begin
            conv_sample <= 1'b0;
        end else begin
            conv_sample <= (state_ff == ACS_CONV) && (mid_tick || conv_tick)
                && (half_ff == (first_ff ? acs_pkg::SH_FIRST
                    : (auto_ff ? acs_pkg::SH_AUTO : acs_pkg::SH_NORMAL)) - 6'h01);
        end
    end

    // ------------------------------------------------------------------
    // selections to the analog side, frozen while converting until the last converter cycle
    // ------------------------------------------------------------------
    wire last_cycle = (state_ff == ACS_CONV) && (half_ff + 6'h02 >= conv_len);
    always_ff @(posedge clk) begin
        if (srst || !en_ff) begin
            conv_sel <= '0;
        end else if (state_ff != ACS_CONV || last_cycle) begin
            conv_sel.chan <= insel_ff[acs_pkg::CH_LSB +: 2];
            conv_sel.refsel <= insel_ff[acs_pkg::REF_LSB +: 2];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            conv_enable <= 1'b0;
            conv_busy <= 1'b0;
        end else begin
            conv_enable <= en_ff;
            conv_busy <= en_ff && (state_ff != ACS_IDLE);  // drops with enable
        end
    end

    // ------------------------------------------------------------------
    // result register and byte-ordered lock
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            res_ff <= 10'h000;
        end else if (done && !lock_ff) begin  // locked result is dropped
            res_ff <= core_result;
        end
    end

    wire rd_low = rd_go && s_axi_araddr == acs_pkg::OFS_RES_LOW;
    wire rd_high = rd_go && s_axi_araddr == acs_pkg::OFS_RES_HIGH;
    always_ff @(posedge clk) begin
        if (srst) begin
            lock_ff <= 1'b0;
        end else if (rd_high) begin
            lock_ff <= 1'b0;
        end else if (rd_low) begin
            lock_ff <= 1'b1;
        end
    end

    // alignment chosen at read time
    assign low_b = insel_ff[acs_pkg::ALIGN_BIT] ? {res_ff[1:0], 6'h00} : res_ff[7:0];
    assign high_b = insel_ff[acs_pkg::ALIGN_BIT] ? res_ff[9:2] : {6'h00, res_ff[9:8]};

    // ------------------------------------------------------------------
    // control registers; hardware set of flag wins over software clear
    // ------------------------------------------------------------------
    wire wr_a = wr_go && aw_addr_ff == acs_pkg::OFS_CTRL_A && w_strb_ff[0];
    always_ff @(posedge clk) begin
        if (srst) begin
            insel_ff <= 8'h00;
            en_ff <= 1'b0;
            ate_ff <= 1'b0;
            ps_ff <= 3'h0;
            ts_ff <= 3'h0;
        end else begin
            if (wr_go && aw_addr_ff == acs_pkg::OFS_INPUT_SEL && w_strb_ff[0]) begin
                insel_ff <= w_data_ff[7:0];
            end
            if (wr_a) begin
                en_ff <= w_data_ff[acs_pkg::EN_BIT];
                ate_ff <= w_data_ff[acs_pkg::ATE_BIT];
                ps_ff <= w_data_ff[acs_pkg::PS_LSB +: 3];
            end
            if (wr_go && aw_addr_ff == acs_pkg::OFS_CTRL_B && w_strb_ff[0]) begin
                ts_ff <= w_data_ff[acs_pkg::TS_LSB +: 3];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            flag_ff <= 1'b0;
        end else if (done) begin
            flag_ff <= 1'b1;  // even when result dropped
        end else if (wr_a && w_data_ff[acs_pkg::FLAG_BIT]) begin
            flag_ff <= 1'b0;
        end
    end

    // start bit: set from write or trigger until conversion finishes, held while free running
    always_ff @(posedge clk) begin
        if (srst) begin
            start_ff <= 1'b0;
        end else begin
            start_ff <= (state_ff != ACS_IDLE && !(done && !(ate_ff && ts_ff == 3'h0)))
                || (soft_req_ff && en_ff) || sw_start;
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------------
    assign wr_go = aw_got_ff && w_got_ff && !s_axi_bvalid;
    assign rd_go = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge clk) begin
        if (srst) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= acs_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_got_ff && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_got_ff && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_ff <= acs_pkg::OFS_RES_HIGH && aw_addr_ff[1:0] == 2'h0)
                    ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        case (s_axi_araddr)
            acs_pkg::OFS_INPUT_SEL: rd_byte = insel_ff;
            acs_pkg::OFS_CTRL_A: rd_byte = {en_ff, start_ff, ate_ff, flag_ff, 1'b0, ps_ff};
            acs_pkg::OFS_CTRL_B: rd_byte = {5'h00, ts_ff};
            acs_pkg::OFS_RES_LOW: rd_byte = low_b;
            acs_pkg::OFS_RES_HIGH: rd_byte = high_b;
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= acs_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= (s_axi_araddr <= acs_pkg::OFS_RES_HIGH && s_axi_araddr[1:0] == 2'h0)
                    ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // acs_sequencer

/* File: verif/acs_sequencer_sva.sv */
// concurrent checks on the conversion sequencer ports.
// assumes the bench keeps the prescaler at divide by two or by four.
`timescale 1ns/100ps
module acs_sequencer_sva (
    input wire logic clk,
    input wire logic srst,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire acs_pkg::acs_sel_t conv_sel,
    input wire logic conv_enable,
    input wire logic conv_clk,
    input wire logic conv_sample,
    input wire logic conv_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic [7:0] busy_len_ff;

    // length of the current busy run, saturating so long free runs do not wrap
    always_ff @(posedge clk) begin
        if (srst || !conv_busy) begin
            busy_len_ff <= 8'h00;
        end else if (busy_len_ff != 8'hff) begin
            busy_len_ff <= busy_len_ff + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // converter side
    // ------------------------------------------------------------
    off_idle_a: assert property (!conv_enable |-> !conv_busy && !conv_sample)
        else $error("converter active while disabled");
    clk_held_a: assert property (!conv_enable && !$past(conv_enable) |-> !conv_clk)
        else $error("converter clock runs while disabled");
    sample_busy_a: assert property (conv_sample |-> conv_busy)
        else $error("sample strobe outside a conversion");
    sample_pulse_a: assert property (conv_sample |=> !conv_sample)
        else $error("sample strobe wider than one cycle");
    first_sample_a: assert property ($rose(conv_busy) |-> ##[1:120] conv_sample)
        else $error("no sample after conversion start");
    sel_hold_a: assert property ($rose(conv_busy) |=> $stable(conv_sel)[*4])
        else $error("selection moved early in a conversion");
    // 13 converter cycles at divide by two is 26 system clocks; one spent on the start edge
    busy_len_a: assert property ($fell(conv_busy) && conv_enable |->
        busy_len_ff >= 8'h19)
        else $error("conversion shorter than thirteen converter cycles");

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after address taken");

    cover property ($fell(conv_busy));
    cover property (conv_sample && conv_busy);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule // acs_sequencer_sva

bind acs_sequencer acs_sequencer_sva u_sva (.clk, .srst, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .conv_sel, .conv_enable, .conv_clk,
    .conv_sample, .conv_busy);

/* File: verif/acs_sequencer_tb.sv */
// self-checking bench for the conversion sequencer, driven over axi4-lite.
// assumes the analog core is stood in for by the bench driving core_result.
`timescale 1ns/100ps
module acs_sequencer_tb;
    localparam logic [31:0] EN = 32'h00000001 << acs_pkg::EN_BIT;
    localparam logic [31:0] ST = 32'h00000001 << acs_pkg::START_BIT;
    localparam logic [31:0] ATE = 32'h00000001 << acs_pkg::ATE_BIT;
    localparam logic [31:0] FL = 32'h00000001 << acs_pkg::FLAG_BIT;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [7:0] trig_src = 8'h00;
    logic [9:0] core_result = 10'h000;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    acs_pkg::acs_sel_t conv_sel;
    logic conv_enable, conv_clk, conv_sample, conv_busy;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_samples = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h000081a7;

    acs_sequencer #(.TRIG_W(8)) dut (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .trig_src, .core_result, .conv_sel, .conv_enable, .conv_clk,
        .conv_sample, .conv_busy);

    // 250 mhz system clock
    always #2 clk = ~clk;

    // sample strobes count conversions, since busy stays high in free running
    always @(posedge clk) begin
        cycles++;
        if (conv_sample === 1'b1) n_samples++;
        if (cycles == 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] exp_lo(logic [9:0] r, logic left);
        return left ? {24'h000000, r[1:0], 6'h00} : {24'h000000, r[7:0]};
    endfunction
    function automatic logic [31:0] exp_hi(logic [9:0] r, logic left);
        return left ? {24'h000000, r[9:2]} : {30'h00000000, r[9:8]};
    endfunction

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // handshakes are judged at the falling edge, where both sides have settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw_ok, w_ok, ta, tw;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(negedge clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            aw_ok = aw_ok | ta;
            w_ok = w_ok | tw;
        end
        do @(negedge clk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        @(posedge clk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge clk); while (s_axi_arready !== 1'b1);
        @(posedge clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge clk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        @(posedge clk);
        s_axi_rready <= 1'b0;
    endtask

    // poll until the completion flag shows; single or edge-started runs drop the start bit
    task automatic wait_flag();
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 200; i++) begin
            rd(acs_pkg::OFS_CTRL_A, d, r);
            if (d[acs_pkg::FLAG_BIT] === 1'b1) break;
        end
        chk("flag", {31'h0, d[acs_pkg::FLAG_BIT]}, 32'h1);
        chk("start after end", {31'h0, d[acs_pkg::START_BIT]}, 32'h0);
    endtask

    task automatic run_conv(input logic [9:0] res);
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk);
        core_result <= res;
        wr(acs_pkg::OFS_CTRL_A, EN | ST | FL, r);
        rd(acs_pkg::OFS_CTRL_A, d, r);
        chk("start busy", {31'h0, d[acs_pkg::START_BIT]}, 32'h1);
        wait_flag();
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d, t;
        logic [1:0] r;
        logic [9:0] res, nres;
        int n0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd(8'(i * 4), d, r);
            chk("reset value", d, 32'h00000000);
        end
        rd(8'h14, d, r);
        chk("unmapped read", {r, d[29:0]}, {acs_pkg::RESP_SLVERR, 30'h00000000});
        wr(8'h02, 32'hffffffff, r);
        chk("unaligned write", {30'h00000000, r}, {30'h00000000, acs_pkg::RESP_SLVERR});
        $display("test registers done");
        wr(acs_pkg::OFS_INPUT_SEL, 32'h00000000, r);
        wr(acs_pkg::OFS_CTRL_A, EN, r);
        @(posedge clk);
        chk("enable out", {31'h0, conv_enable}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            t = xs();
            res = t[9:0];
            wr(acs_pkg::OFS_INPUT_SEL, 32'(i % 2) << acs_pkg::ALIGN_BIT, r);
            run_conv(res);
            rd(acs_pkg::OFS_RES_LOW, d, r);
            chk("result low", d, exp_lo(res, 1'(i % 2)));
            rd(acs_pkg::OFS_RES_HIGH, d, r);
            chk("result high", d, exp_hi(res, 1'(i % 2)));
        end
        $display("test alignment done");
        wr(acs_pkg::OFS_INPUT_SEL, 32'h00000000, r);
        t = xs();
        res = t[9:0];
        nres = ~res;
        run_conv(res);
        rd(acs_pkg::OFS_RES_LOW, d, r);
        run_conv(nres);
        rd(acs_pkg::OFS_RES_HIGH, d, r);
        chk("locked high", d, exp_hi(res, 1'b0));
        run_conv(nres);
        rd(acs_pkg::OFS_RES_LOW, d, r);
        chk("unlocked low", d, exp_lo(nres, 1'b0));
        rd(acs_pkg::OFS_RES_HIGH, d, r);
        chk("unlocked high", d, exp_hi(nres, 1'b0));
        $display("test lock done");
        wr(acs_pkg::OFS_INPUT_SEL, 32'h00000041, r);
        @(posedge clk);
        chk("sel idle", {28'h0, conv_sel}, 32'h5);
        wr(acs_pkg::OFS_CTRL_A, EN | ST | FL, r);
        wr(acs_pkg::OFS_INPUT_SEL, 32'h00000082, r);
        chk("sel held", {28'h0, conv_sel}, 32'h5);
        wait_flag();
        repeat (2) @(posedge clk);
        chk("sel after", {28'h0, conv_sel}, 32'ha);
        $display("test channel done");
        // trigger sources 1 to 7: a held level and a second edge mid-run give one start
        for (int s = 1; s < 8; s++) begin
            wr(acs_pkg::OFS_CTRL_B, 32'(s), r);
            wr(acs_pkg::OFS_CTRL_A, EN | ATE | FL, r);
            n0 = n_samples;
            @(posedge clk);
            trig_src <= 8'h01 << s;
            repeat (8) @(posedge clk);
            trig_src <= 8'h00;
            @(posedge clk);
            trig_src <= 8'h01 << s;
            wait_flag();
            repeat (60) @(posedge clk);
            chk("trigger starts", 32'(n_samples - n0), 32'h00000001);
            trig_src <= 8'h00;
        end
        n0 = n_samples;
        wr(acs_pkg::OFS_CTRL_A, EN | ATE | ST | FL, r);
        wait_flag();
        chk("soft start in auto", 32'(n_samples - n0), 32'h00000001);
        $display("test trigger done");
        wr(acs_pkg::OFS_CTRL_B, 32'h00000000, r);
        n0 = n_samples;
        wr(acs_pkg::OFS_CTRL_A, EN | ATE | ST | FL, r);
        repeat (200) @(posedge clk);
        rd(acs_pkg::OFS_CTRL_A, d, r);
        chk("free start bit", {31'h0, d[acs_pkg::START_BIT]}, 32'h1);
        chk("free runs", {31'h0, 1'(n_samples - n0 >= 6)}, 32'h1);
        wr(acs_pkg::OFS_CTRL_A, 32'h00000000, r);
        repeat (4) @(posedge clk);
        chk("disabled", {29'h0, conv_enable, conv_busy, conv_clk}, 32'h0);
        chk("sel off", {28'h0, conv_sel}, 32'h0);
        // start written with enable from off: first long conversion at divide by four
        wr(acs_pkg::OFS_CTRL_A, EN | ST | FL | 32'h00000002, r); // valid clock
        wait_flag();
        $display("test free running done");
        test_done();
    end
endmodule // acs_sequencer_tb
